// [design/sync_serial_port_defines.vh]
// Purpose: shared constants of the synchronous serial port core
// Assumes: 8-bit register port, 10 MHz core clock
// Notes: definitions only
`ifndef SYNC_SERIAL_PORT_DEFINES_VH
`define SYNC_SERIAL_PORT_DEFINES_VH
// register addresses
`define ADDR_INT_FLAG 8'h0C
`define ADDR_BUFFER 8'h13
`define ADDR_CONTROL 8'h14
`define ADDR_CONTROL_TWO 8'h91
`define ADDR_STATUS 8'h94
// field positions
`define CTL_WRITE_COLLISION_FLAG 7
`define CTL_OV 6
`define CTL_EN 5
`define CTL_CKP 4
`define CTL_MODE_HI 3
`define STAT_SMP 7
`define STAT_CKE 6
`define STAT_BF 0
`define C2_GENERAL_CALL_ENABLE 7
`define C2_ACK_STATUS 6
`define C2_ACK_DATA 5
`define C2_ACK_REQ 4
`define C2_RECV_REQ 3
`define C2_STOP_REQ 2
`define C2_RSTART_REQ 1
`define C2_START_REQ 0
`define INT_FLAG_BIT 3
`define DIR_C_SDO 5
`define DIR_C_SCK 3
`define DIR_A_SS 5
// reset value of every register
`define REG_RESET 8'h00
// mode select codes
`define MODE_MASTER_DIV4 4'h0
`define MODE_MASTER_DIV16 4'h1
`define MODE_MASTER_DIV64 4'h2
`define MODE_MASTER_TMR2 4'h3
`define MODE_SLAVE_SS 4'h4
`define MODE_SLAVE_NOSS 4'h5
`define MODE_I2C_SLAVE7 4'h6
`define MODE_I2C_SLAVE10 4'h7
`define MODE_I2C_MASTER 4'h8
// last core cycle of one sck half period (half periods 2, 8, 32 cycles)
`define SPI_HALF_LAST_DIV4 6'h01
`define SPI_HALF_LAST_DIV16 6'h07
`define SPI_HALF_LAST_DIV64 6'h1F
`define SPI_HALF_COUNT 5'h10
`define SPI_LAST_WINDOW 5'h0F
`define BITS_LAST 4'h7
// i2c quarter bit time in core cycles minus one (chosen default)
`define I2C_QUARTER_LAST 8'h18
`define I2C_LAST_QUARTER 2'h3
`define I2C_SAMPLE_QUARTER 2'h1
`define I2C_XMIT_LAST_SLOT 4'h8
`define I2C_RECV_LAST_SLOT 4'h7
`define GENERAL_CALL_ADDR 8'h00
// i2c master states, one-hot
`define I2C_ST_IDLE 7'h01
`define I2C_ST_START 7'h02
`define I2C_ST_RSTART 7'h04
`define I2C_ST_STOP 7'h08
`define I2C_ST_ACK 7'h10
`define I2C_ST_RECV 7'h20
`define I2C_ST_XMIT 7'h40
// line levels per quarter q0..q3 as bits 0..3, 1 means released
`define PAT_START_SDA 4'h3
`define PAT_START_SCL 4'h7
`define PAT_RSTART_SDA 4'h3
`define PAT_RSTART_SCL 4'h6
`define PAT_STOP_SDA 4'h8
`define PAT_STOP_SCL 4'hE
`define PAT_DATA_SCL 4'h6
`endif

// [design/sync_serial_port_spi_core.v]
// Purpose: synchronous serial port core, spi modes plus i2c master sequences
// Assumes: register port with read data one cycle after the read strobe
// Notes: partner pins are synchronised except serial_data_in_in in spi master mode; slave timing lags sck by three cycles
`timescale 1ns/1ns
`include "sync_serial_port_defines.vh"
module sync_serial_port_spi_core (
	// clock, reset, enable
	input wire core_clk_in,
	input wire reset_n_in,
	input wire ce_in,
	// register port
	input wire [7:0] addr_in,
	input wire [7:0] wr_data_in,
	input wire wr_in,
	input wire rd_in,
	output reg [7:0] rd_data_out,
	// general purpose direction bits and timer2 match pulse
	input wire [7:0] port_c_direction_in,
	input wire [7:0] port_a_direction_in,
	input wire timer2_match_in,
	// spi pins
	input wire sck_in,
	output reg sck_out,
	output reg sck_oe_out,
	input wire serial_data_in_in,
	output reg serial_data_out_out,
	output reg serial_data_out_oe_out,
	input wire ss_n_in,
	// i2c pins, oe high pulls the line low
	input wire scl_in,
	input wire sda_in,
	output reg scl_oe_out,
	output reg sda_oe_out,
	// interrupt flag level
	output reg serial_port_interrupt_flag_out
);
	reg [7:0] buffer, shift;
	reg write_collision_flag, ov, en, clock_polarity, sample_phase, cke, bf, int_flag;
	reg [3:0] mode;
	reg general_call_enable, ack_status, ack_data, ack_req, recv_req, stop_req, rstart_req, start_req;
	reg busy, sck, samp;
	reg [4:0] half;
	reg [5:0] div_cnt;
	reg [3:0] slave_bits;
	reg sck_prev, sda_prev, scl_prev;
	reg [6:0] i2c_state;
	reg [1:0] quarter;
	reg [7:0] qcnt;
	reg [3:0] slot;
	reg i2c_samp;
	reg gc_active;
	reg [3:0] gc_bits;
	reg [7:0] gc_shift;
	reg [7:0] next_rd_data;
	reg [5:0] half_last;
	reg sda_val, scl_val;
	wire sck_q, ss_n_q, scl_q, sda_q, sdi_q;

	function [7:0] shift_in;
		input [7:0] value;
		input in_bit;
		begin
			shift_in = {value[6:0], in_bit};
		end
	endfunction

	function pattern_bit;
		input [3:0] pattern;
		input [1:0] index;
		begin
			pattern_bit = pattern[index];
		end
	endfunction

	sync_two_flop #(.WIDTH(5)) pin_sync (
		.core_clk_in(core_clk_in),
		.reset_n_in(reset_n_in),
		.ce_in(ce_in),
		.d_in({sck_in, ss_n_in, scl_in, sda_in, serial_data_in_in}),
		.q_out({sck_q, ss_n_q, scl_q, sda_q, sdi_q})
	);

	wire is_master = en & (mode[`CTL_MODE_HI:2] == 2'b00);
	wire is_slave = en & ((mode == `MODE_SLAVE_SS) | (mode == `MODE_SLAVE_NOSS));
	wire is_i2c_master = en & (mode == `MODE_I2C_MASTER);
	wire is_i2c_slave = en & ((mode == `MODE_I2C_SLAVE7) | (mode == `MODE_I2C_SLAVE10));
	wire cpha = ~cke;
	wire any_req = ack_req | recv_req | stop_req | rstart_req | start_req;
	wire i2c_idle = (i2c_state == `I2C_ST_IDLE) & ~any_req;
	wire ss_active = (mode == `MODE_SLAVE_NOSS) | ~ss_n_q;
	wire slave_active = is_slave & ss_active;
	wire xfer_busy = busy | (slave_bits != 4'h0) | (is_i2c_master & ~i2c_idle);
	wire buf_wr = wr_in & (addr_in == `ADDR_BUFFER);
	wire buf_rd = rd_in & (addr_in == `ADDR_BUFFER);
	wire buf_accept = buf_wr & ~xfer_busy;

	always @* begin
		half_last = `SPI_HALF_LAST_DIV4;
		case (mode)
			`MODE_MASTER_DIV16: half_last = `SPI_HALF_LAST_DIV16;
			`MODE_MASTER_DIV64: half_last = `SPI_HALF_LAST_DIV64;
			default: half_last = `SPI_HALF_LAST_DIV4;
		endcase
	end
	// timer2 output/2: one sck half period per match pulse
	wire half_tick = busy & ((mode == `MODE_MASTER_TMR2) ? timer2_match_in : (div_cnt == half_last));
	wire [4:0] cpha5 = {4'h0, cpha};
	wire in_window = half >= cpha5;
	wire [4:0] k = half - cpha5;
	wire master_done = half_tick & in_window & (k == `SPI_LAST_WINDOW);
	wire master_bit = sample_phase ? serial_data_in_in : samp;

	// slave edges against the shared idle level
	wire sck_change = sck_q != sck_prev;
	wire lead = sck_change & (sck_prev == clock_polarity);
	wire trail = sck_change & (sck_prev != clock_polarity);
	wire slave_shift = slave_active & trail;
	wire slave_bit = cpha ? sdi_q : samp;
	wire slave_done = slave_shift & (slave_bits == `BITS_LAST);

	// i2c master quarter timing
	wire i2c_run = is_i2c_master & (i2c_state != `I2C_ST_IDLE);
	wire q_tick = i2c_run & (qcnt == `I2C_QUARTER_LAST);
	wire slot_end = q_tick & (quarter == `I2C_LAST_QUARTER);
	wire recv_done = slot_end & (i2c_state == `I2C_ST_RECV) & (slot == `I2C_RECV_LAST_SLOT);
	wire xmit_done = slot_end & (i2c_state == `I2C_ST_XMIT) & (slot == `I2C_XMIT_LAST_SLOT);
	wire cond_done = slot_end & ((i2c_state == `I2C_ST_START) | (i2c_state == `I2C_ST_RSTART) |
		(i2c_state == `I2C_ST_STOP) | (i2c_state == `I2C_ST_ACK));

	wire rx_done = master_done | slave_done | recv_done;
	wire [7:0] rx_byte = master_done ? shift_in(shift, master_bit) :
		(slave_done ? shift_in(shift, slave_bit) : shift_in(shift, i2c_samp));
	wire [7:0] gc_byte = shift_in(gc_shift, sda_q);

	// i2c line levels for current state and quarter
	always @* begin
		sda_val = 1'b1;
		scl_val = pattern_bit(`PAT_DATA_SCL, quarter);
		case (i2c_state)
			`I2C_ST_START: begin
				sda_val = pattern_bit(`PAT_START_SDA, quarter);
				scl_val = pattern_bit(`PAT_START_SCL, quarter);
			end
			`I2C_ST_RSTART: begin
				sda_val = pattern_bit(`PAT_RSTART_SDA, quarter);
				scl_val = pattern_bit(`PAT_RSTART_SCL, quarter);
			end
			`I2C_ST_STOP: begin
				sda_val = pattern_bit(`PAT_STOP_SDA, quarter);
				scl_val = pattern_bit(`PAT_STOP_SCL, quarter);
			end
			// ack data drives the ack slot
			`I2C_ST_ACK: sda_val = ack_data;
			`I2C_ST_XMIT: sda_val = (slot == `I2C_XMIT_LAST_SLOT) ? 1'b1 : shift[7];
			default: sda_val = 1'b1;
		endcase
	end

	// only mapped registers are readable; shift register has no address
	always @* begin
		next_rd_data = 8'h00;
		case (addr_in)
			`ADDR_BUFFER: next_rd_data = buffer;
			`ADDR_CONTROL: begin
				next_rd_data[`CTL_WRITE_COLLISION_FLAG] = write_collision_flag;
				next_rd_data[`CTL_OV] = ov;
				next_rd_data[`CTL_EN] = en;
				next_rd_data[`CTL_CKP] = clock_polarity;
				next_rd_data[`CTL_MODE_HI:0] = mode;
			end
			`ADDR_STATUS: begin
				next_rd_data[`STAT_SMP] = sample_phase;
				next_rd_data[`STAT_CKE] = cke;
				next_rd_data[`STAT_BF] = bf;
			end
			`ADDR_CONTROL_TWO: next_rd_data = {general_call_enable, ack_status, ack_data, ack_req,
				recv_req, stop_req, rstart_req, start_req};
			`ADDR_INT_FLAG: next_rd_data[`INT_FLAG_BIT] = int_flag;
			default: next_rd_data = 8'h00;
		endcase
	end

	always @(posedge core_clk_in) begin
		if (!reset_n_in) begin
			{write_collision_flag, ov, en, clock_polarity, mode} <= `REG_RESET;
			{general_call_enable, ack_status, ack_data, ack_req, recv_req, stop_req, rstart_req, start_req} <= `REG_RESET;
			buffer <= `REG_RESET;
			shift <= `REG_RESET;
			{sample_phase, cke, bf, int_flag, busy, sck, samp} <= 7'h00;
			half <= 5'h00;
			div_cnt <= 6'h00;
			slave_bits <= 4'h0;
			{sck_prev, sda_prev, scl_prev} <= 3'h0;
			i2c_state <= `I2C_ST_IDLE;
			quarter <= 2'h0;
			qcnt <= 8'h00;
			slot <= 4'h0;
			i2c_samp <= 1'b0;
			gc_active <= 1'b0;
			gc_bits <= 4'h0;
			gc_shift <= `REG_RESET;
			rd_data_out <= 8'h00;
			{sck_out, sck_oe_out, serial_data_out_out, serial_data_out_oe_out} <= 4'h0;
			{scl_oe_out, sda_oe_out, serial_port_interrupt_flag_out} <= 3'h0;
		end else if (ce_in) begin
			sck_prev <= sck_q;
			sda_prev <= sda_q;
			scl_prev <= scl_q;
			rd_data_out <= rd_in ? next_rd_data : 8'h00;
			// software writes first so hardware sets below win
			if (wr_in) begin
				case (addr_in)
					`ADDR_CONTROL: begin
						write_collision_flag <= wr_data_in[`CTL_WRITE_COLLISION_FLAG];
						ov <= wr_data_in[`CTL_OV];
						en <= wr_data_in[`CTL_EN];
						clock_polarity <= wr_data_in[`CTL_CKP];
						mode <= wr_data_in[`CTL_MODE_HI:0];
					end
					`ADDR_STATUS: begin
						sample_phase <= wr_data_in[`STAT_SMP];
						cke <= wr_data_in[`STAT_CKE];
					end
					`ADDR_CONTROL_TWO: begin
						general_call_enable <= wr_data_in[`C2_GENERAL_CALL_ENABLE];
						ack_data <= wr_data_in[`C2_ACK_DATA];
						if (i2c_idle) begin
							ack_req <= wr_data_in[`C2_ACK_REQ];
							recv_req <= wr_data_in[`C2_RECV_REQ];
							stop_req <= wr_data_in[`C2_STOP_REQ];
							rstart_req <= wr_data_in[`C2_RSTART_REQ];
							start_req <= wr_data_in[`C2_START_REQ];
						end
					end
					`ADDR_INT_FLAG: int_flag <= wr_data_in[`INT_FLAG_BIT];
					default: ;
				endcase
			end
			if (buf_rd)
				bf <= 1'b0;
			if (buf_wr & xfer_busy)
				write_collision_flag <= 1'b1;
			// written byte held in buffer and shifter
			if (buf_accept) begin
				buffer <= wr_data_in;
				shift <= wr_data_in;
			end
			if (buf_accept & is_master) begin
				busy <= 1'b1;
				half <= 5'h00;
				div_cnt <= 6'h00;
			end
			if (busy)
				div_cnt <= half_tick ? 6'h00 : div_cnt + 6'h01;
			if (!busy)
				sck <= clock_polarity;
			// sixteen half periods, data moved msb first
			if (half_tick) begin
				if (half < `SPI_HALF_COUNT)
					sck <= ~sck;
				if (in_window & ~k[0] & ~sample_phase)
					samp <= serial_data_in_in;
				// shifting in regardless of data out direction
				if (in_window & k[0])
					shift <= shift_in(shift, master_bit);
				if (master_done)
					busy <= 1'b0;
				else
					half <= half + 5'h01;
			end
			// slave: capture on leading edge when clock edge select is 1
			if (slave_active & lead & ~cpha)
				samp <= sdi_q;
			if (slave_shift) begin
				shift <= shift_in(shift, slave_bit);
				slave_bits <= slave_done ? 4'h0 : slave_bits + 4'h1;
			end
			if (is_slave & ~ss_active)
				slave_bits <= 4'h0;
			// i2c master sequencer
			if (is_i2c_master & (i2c_state == `I2C_ST_IDLE)) begin
				quarter <= 2'h0;
				qcnt <= 8'h00;
				slot <= 4'h0;
				if (start_req)
					i2c_state <= `I2C_ST_START;
				else if (rstart_req)
					i2c_state <= `I2C_ST_RSTART;
				else if (stop_req)
					i2c_state <= `I2C_ST_STOP;
				else if (ack_req)
					i2c_state <= `I2C_ST_ACK;
				else if (recv_req)
					i2c_state <= `I2C_ST_RECV;
				else if (buf_accept)
					i2c_state <= `I2C_ST_XMIT;
			end
			if (i2c_run) begin
				qcnt <= q_tick ? 8'h00 : qcnt + 8'h01;
				scl_oe_out <= ~scl_val;
				sda_oe_out <= ~sda_val;
				if (q_tick) begin
					quarter <= quarter + 2'h1;
					if (quarter == `I2C_SAMPLE_QUARTER)
						i2c_samp <= sda_q;
				end
				if (slot_end) begin
					slot <= slot + 4'h1;
					if (slot < `I2C_XMIT_LAST_SLOT)
						shift <= shift_in(shift, i2c_samp);
				end
				if (xmit_done)
					ack_status <= i2c_samp;
				if (cond_done | xmit_done | recv_done) begin
					i2c_state <= `I2C_ST_IDLE;
					int_flag <= 1'b1;
					{ack_req, stop_req, rstart_req, start_req} <= 4'h0;
					if (recv_done)
						recv_req <= 1'b0;
				end
			end
			// load buffer, set full and interrupt
			if (rx_done) begin
				int_flag <= 1'b1;
				// overflow in spi slave and i2c master modes, never in spi master
				if (bf & ~is_master)
					ov <= 1'b1;
				else begin
					buffer <= rx_byte;
					bf <= 1'b1;
				end
			end
			// general call watch in i2c slave mode
			if (is_i2c_slave & scl_q & sda_prev & ~sda_q) begin
				gc_active <= 1'b1;
				gc_bits <= 4'h0;
			end else if (is_i2c_slave & gc_active & scl_q & ~scl_prev) begin
				gc_shift <= gc_byte;
				gc_bits <= gc_bits + 4'h1;
				if (gc_bits == `BITS_LAST) begin
					gc_active <= 1'b0;
					if (general_call_enable & (gc_byte == `GENERAL_CALL_ADDR))
						int_flag <= 1'b1;
				end
			end
			// disabled port releases pins and resets engines
			if (!en) begin
				busy <= 1'b0;
				slave_bits <= 4'h0;
				i2c_state <= `I2C_ST_IDLE;
				{ack_req, recv_req, stop_req, rstart_req, start_req} <= 5'h00;
				gc_active <= 1'b0;
				scl_oe_out <= 1'b0;
				sda_oe_out <= 1'b0;
			end
			sck_out <= sck;
			sck_oe_out <= is_master & ~port_c_direction_in[`DIR_C_SCK];
			serial_data_out_out <= shift[7];
			// msb already on data out before first edge
			serial_data_out_oe_out <= ~port_c_direction_in[`DIR_C_SDO] &
				(is_master | (slave_active & ((mode == `MODE_SLAVE_NOSS) |
				port_a_direction_in[`DIR_A_SS])));
			serial_port_interrupt_flag_out <= int_flag;
		end
	end
endmodule // sync_serial_port_spi_core

// [design/sync_two_flop.v]
// Purpose: two flip-flop synchroniser for pins driven by the link partner
// Assumes: synchronous active-low reset, clock enable freezes state
// Notes: the first stage is read by the second stage only
`timescale 1ns/1ns
module sync_two_flop #(
	parameter WIDTH = 5
) (
	// clock and reset
	input wire core_clk_in,
	input wire reset_n_in,
	input wire ce_in,
	// data
	input wire [WIDTH-1:0] d_in,
	output reg [WIDTH-1:0] q_out
);
	reg [WIDTH-1:0] stage_one;
	always @(posedge core_clk_in) begin
		if (!reset_n_in) begin
			stage_one <= {WIDTH{1'b0}};
			q_out <= {WIDTH{1'b0}};
		end else if (ce_in) begin
			stage_one <= d_in;
			q_out <= stage_one;
		end
	end
endmodule // sync_two_flop

// [dv/serial_port_props.sv]
// Purpose: port checker for the serial port core
// Assumes: control is written only while no transfer runs
// Notes: control bits are shadowed from bus writes
`timescale 1ns/1ns
module serial_port_props (
	// clock and bus
	input wire core_clk_in,
	input wire reset_n_in,
	input wire [7:0] addr_in,
	input wire [7:0] wr_data_in,
	input wire wr_in,
	input wire rd_in,
	input wire [7:0] rd_data_out,
	// pins
	input wire [7:0] port_c_direction_in,
	input wire sck_out,
	input wire serial_data_out_oe_out,
	input wire scl_oe_out,
	input wire sda_oe_out,
	input wire serial_port_interrupt_flag_out
);
	reg [7:0] ctl;
	wire wr_buf = wr_in && addr_in == 8'h13;
	wire wr_ctl = wr_in && addr_in == 8'h14;
	wire wr_c2 = wr_in && addr_in == 8'h91 && ctl == 8'h28;
	wire mapped = addr_in inside {8'h0C, 8'h13, 8'h14, 8'h91, 8'h94};
	wire master = ctl[5] && ctl[3:2] == 2'b00;
	// shadow copy; hardware-set flags are not tracked
	always @(posedge core_clk_in) begin
		if (!reset_n_in)
			ctl <= 8'h00;
		else if (wr_ctl)
			ctl <= wr_data_in;
	end
	default clocking @(posedge core_clk_in); endclocking
	default disable iff (!reset_n_in);
	a_read_unmapped: assert property (
		rd_in && !mapped |=> rd_data_out == 8'h00) else $error("unmapped read not zero");
	a_flag_set: assert property (
		wr_in && addr_in == 8'h0C && wr_data_in[3] |-> ##2 serial_port_interrupt_flag_out)
		else $error("flag write not seen");
	a_write_collision_flag_busy: assert property (
		wr_buf && master ##1 wr_buf ##1 rd_in && addr_in == 8'h14 |=> rd_data_out[7])
		else $error("collision not flagged");
	a_bf_clear: assert property (
		rd_in && addr_in == 8'h13 ##2 rd_in && addr_in == 8'h94 |=> !rd_data_out[0])
		else $error("buffer full kept after read");
	a_sck_idle: assert property (
		wr_ctl && wr_data_in[5] && wr_data_in[3:2] == 2'b00 ##1 !wr_buf [*3]
		|-> sck_out == ctl[4]) else $error("clock idle level wrong");
	a_sdo_dir: assert property (
		serial_data_out_oe_out |-> $past(!port_c_direction_in[5]))
		else $error("data out driven against direction");
	a_start_cond: assert property (
		wr_c2 && wr_data_in[0] |-> ##[1:110] sda_oe_out && !scl_oe_out)
		else $error("start condition missing");
	a_stop_cond: assert property (
		wr_c2 && wr_data_in[2:0] == 3'b100
		|-> ##[1:110] (sda_oe_out && !scl_oe_out) ##[1:40] !sda_oe_out)
		else $error("stop condition missing");
	cover property (wr_buf && master ##1 wr_buf);
	cover property (sda_oe_out && !scl_oe_out);
	cover property ($rose(serial_port_interrupt_flag_out));
endmodule // serial_port_props
bind sync_serial_port_spi_core serial_port_props serial_port_props_inst (.core_clk_in,
	.reset_n_in, .addr_in, .wr_data_in, .wr_in, .rd_in, .rd_data_out, .port_c_direction_in,
	.sck_out, .serial_data_out_oe_out, .scl_oe_out, .sda_oe_out,
	.serial_port_interrupt_flag_out);

// [dv/spi_partner.sv]
// Purpose: spi slave partner with clock edge select 1
// Assumes: sck half period of at least two core cycles
// Notes: edges seen on the core clock; load re-arms the byte
`timescale 1ns/1ns
module spi_partner (
	// clock and control
	input wire clk_in,
	input wire reset_n_in,
	input wire ckp_in,
	input wire load_in,
	input wire [7:0] tx_in,
	// link
	input wire sck_in,
	input wire sdo_in,
	output wire sdi_out,
	output reg [7:0] rx_out
);
	reg [7:0] shreg;
	reg last;
	wire lead = sck_in != last && sck_in != ckp_in;
	wire trail = sck_in != last && sck_in == ckp_in;
	// next bit shows as soon as the trailing edge is seen, as a real slave would
	assign sdi_out = trail ? shreg[6] : shreg[7];
	always @(posedge clk_in) begin
		last <= sck_in;
		if (!reset_n_in || load_in) begin
			shreg <= tx_in;
		end else if (lead) begin
			rx_out <= {rx_out[6:0], sdo_in};
		end else if (trail) begin
			shreg <= {shreg[6:0], 1'b0};
		end
	end
endmodule // spi_partner

// [dv/testbench.sv]
// Purpose: self-checking bench for the serial port core
// Assumes: partner answers every master byte
// Notes: i2c lines are pulled up with no slave, so every ack reads as nack
`timescale 1ns/1ns
module testbench;
	reg core_clk_in = 0;
	reg reset_n_in = 0;
	reg [7:0] addr_in = 0, wr_data_in = 0, port_c_direction_in = 0, tx = 0, v, h;
	reg wr_in = 0, rd_in = 0, timer2_match_in = 0, load = 0, clock_polarity = 0, ssck = 0, slv = 0;
	reg [1:0] t2 = 0;
	wire [7:0] rd_data_out, prx;
	wire sck_out, sck_oe_out, serial_data_in_in, serial_data_out, sdo_oe, scl_oe, sda_oe, flag;
	// undriven data line shows the inverse level
	wire sdo_line = sdo_oe ? serial_data_out : ~serial_data_out;
	integer errors = 0, samples_checked = 0, cyc = 0, i, n;
	always #50 core_clk_in = ~core_clk_in;
	always @(posedge core_clk_in) begin
		t2 <= t2 + 2'h1;
		timer2_match_in <= t2 == 2'h3;
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			errors = errors + 1;
			stop_test;
		end
	end
	sync_serial_port_spi_core sync_serial_port_spi_core_inst (.core_clk_in, .reset_n_in,
		.ce_in(1'b1), .addr_in, .wr_data_in, .wr_in, .rd_in, .rd_data_out,
		.port_c_direction_in, .port_a_direction_in(8'h20), .timer2_match_in,
		.sck_in(ssck), .sck_out, .sck_oe_out, .serial_data_in_in,
		.serial_data_out_out(serial_data_out), .serial_data_out_oe_out(sdo_oe), .ss_n_in(1'b1),
		.scl_in(~scl_oe), .sda_in(~sda_oe), .scl_oe_out(scl_oe), .sda_oe_out(sda_oe),
		.serial_port_interrupt_flag_out(flag));
	spi_partner spi_partner_inst (.clk_in(core_clk_in), .reset_n_in, .ckp_in(clock_polarity),
		.load_in(load), .tx_in(tx), .sck_in(slv ? ssck : sck_out), .sdo_in(sdo_line),
		.sdi_out(serial_data_in_in), .rx_out(prx));
	task check(input [7:0] seen, input [7:0] exp);
		begin
			samples_checked = samples_checked + 1;
			if (seen !== exp) begin
				errors = errors + 1;
				$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
			end
		end
	endtask
	task wr(input [7:0] a, input [7:0] d);
		begin
			rd_in <= 1'b0;
			wr_in <= 1'b1;
			addr_in <= a;
			wr_data_in <= d;
			@(posedge core_clk_in);
		end
	endtask
	task rd(input [7:0] a, input [7:0] exp);
		begin
			wr_in <= 1'b0;
			rd_in <= 1'b1;
			addr_in <= a;
			@(posedge core_clk_in);
			rd_in <= 1'b0;
			@(posedge core_clk_in);
			check(rd_data_out, exp);
		end
	endtask
	task nop(input integer k);
		begin
			wr_in <= 1'b0;
			rd_in <= 1'b0;
			repeat (k) @(posedge core_clk_in);
		end
	endtask
	task waitflag;
		integer k;
		begin
			nop(2);
			for (k = 0; k < 1200 && flag !== 1'b1; k = k + 1)
				@(posedge core_clk_in);
			check({7'h00, flag}, 8'h01);
		end
	endtask
	// bench clocks both slaves: eight leading and eight trailing edges
	task slave_byte;
		begin
			repeat (16) begin
				nop(8);
				ssck <= ~ssck;
			end
			nop(8);
		end
	endtask
	task stop_test;
		begin
			if (errors == 0 && samples_checked > 0)
				$display("All tests passed");
			else
				$display("Some tests failed");
			$finish;
		end
	endtask
	initial begin
		repeat (8) @(posedge core_clk_in);
		reset_n_in <= 1'b1;
		@(posedge core_clk_in);
		for (i = 0; i < 5; i = i + 1)
			rd(8'(40'h0C_94_91_14_55 >> (8 * i)), 8'h00);
		wr(8'h0C, 8'h08);
		nop(2);
		check({7'h00, flag}, 8'h01);
		wr(8'h94, 8'h40);
		for (i = 0; i < 8; i = i + 1) begin
			clock_polarity = i[2];
			h = 8'(32'h04200802 >> (8 * (i % 4)));
			v = {3'b001, clock_polarity, 2'b00, i[1:0]};
			port_c_direction_in <= {2'b00, i == 1, 5'h00};
			wr(8'h94, {i[2], 7'h40});
			wr(8'h0C, 8'h00);
			wr(8'h14, v);
			nop(4);
			check({7'h00, sck_out}, {7'h00, clock_polarity});
			check({7'h00, sck_oe_out}, 8'h01);
			tx = 8'hC3 ^ i;
			load <= 1'b1;
			nop(1);
			load <= 1'b0;
			n = cyc;
			wr(8'h13, 8'h5A + i);
			wr(8'h13, 8'hFF);
			rd(8'h14, v | 8'h80);
			waitflag;
			n = cyc - n;
			check({7'h00, n >= 16 * h && n <= 17 * h + 6}, 8'h01);
			rd(8'h94, {i[2], 7'h41});
			rd(8'h13, tx);
			rd(8'h94, {i[2], 7'h40});
			check(prx, (i == 1) ? ~(8'h5A + i) : 8'h5A + i);
			wr(8'h14, v);
		end
		port_c_direction_in <= 8'h00;
		// slave and i2c checks below need the sample bit clear
		wr(8'h94, 8'h40);
		wr(8'h0C, 8'h00);
		wr(8'h13, 8'h11);
		nop(8);
		wr(8'h14, 8'h00);
		wr(8'h14, 8'h20);
		nop(40);
		check({7'h00, flag}, 8'h00);
		wr(8'h13, 8'h22);
		rd(8'h14, 8'h20);
		nop(40);
		// partner shifted out to zero; reading also empties the buffer
		rd(8'h13, 8'h00);
		clock_polarity = 1'b0;
		slv <= 1'b1;
		wr(8'h14, 8'h25);
		tx = 8'h3C;
		load <= 1'b1;
		nop(1);
		load <= 1'b0;
		wr(8'h13, 8'h96);
		slave_byte;
		check(prx, 8'h96);
		check({7'h00, sck_oe_out}, 8'h00);
		rd(8'h94, 8'h41);
		slave_byte;
		check(prx, 8'h3C);
		rd(8'h14, 8'h65);
		rd(8'h13, 8'h3C);
		wr(8'h14, 8'h28);
		wr(8'h91, 8'hE0);
		rd(8'h91, 8'hA0);
		wr(8'h0C, 8'h00);
		wr(8'h91, 8'h01);
		wr(8'h91, 8'h10);
		wr(8'h13, 8'h77);
		rd(8'h91, 8'h01);
		rd(8'h14, 8'hA8);
		waitflag;
		rd(8'h91, 8'h00);
		wr(8'h14, 8'h28);
		for (i = 0; i < 4; i = i + 1) begin
			wr(8'h0C, 8'h00);
			wr(8'h91, 8'(32'h08_10_04_02 >> (8 * i)));
			waitflag;
			rd(8'h91, 8'h00);
		end
		rd(8'h94, 8'h41);
		rd(8'h13, 8'hFF);
		wr(8'h0C, 8'h00);
		wr(8'h13, 8'hA5);
		waitflag;
		rd(8'h91, 8'h40);
		stop_test;
	end
endmodule // testbench
